// *** inc/gpsen_map.svh ***
// Functional notes
// R1: Eight pins per port, indexed 0 to 7, each independently configured.
// R2: Each pin is input or output with its own driver and pull.
// R3: Drivers: totem-pole, wired-AND, wired-OR, bus-keeper, inverted I/O.
// R4: Optional pull-up or pull-down on inputs and wired configurations.
// R5: Bus-keeper weakly holds last level: pull-up after one, pull-down after zero.
// R6: Each pin can enable slew rate limitation on its output.
// R7: Sense both edges, rising, falling or low level; raise interrupts and events.
// R8: Sensing is synchronous with port clock enabled, asynchronous otherwise; the code samples pins on aclk in both cases.
// R9: Inverted pins are inverted before the sensing logic.
// R10: Asynchronous pin change wakes the device from every sleep mode.
// R11: Two interrupt outputs per port, each with its own pin mask.
// R12: Set, clear and toggle registers change only targeted output and direction bits.
// R13: Changing one pin direction leaves all other directions alone.
// R14: One write applies one configuration to several selected pins.
// R15: Peripheral clock, real-time clock and event channels can drive pins.
// R16: An enabled alternate function overrides the pin's normal function or value.
// R17: Serial, SPI and timer pins can be remapped to alternative locations.
// R18: Interrupt vector is peripheral base word address plus interrupt offset.
// R19: Bank C vector base is word address 0x004.
// R20: Bank R vector base is word address 0x008.
// R21: Bank B vector base is word address 0x04E.
// R22: Banks D, G and M vector bases are 0x060, 0x064 and 0x068.
// R23: First request uses base plus zero, second base plus one vector step.
`ifndef GPSEN_MAP_SVH
`define GPSEN_MAP_SVH
`define GPSEN_DIR      12'h000
`define GPSEN_DIRSET   12'h004
`define GPSEN_DIRCLR   12'h008
`define GPSEN_DIRTGL   12'h00C
`define GPSEN_OUT      12'h010
`define GPSEN_OUTSET   12'h014
`define GPSEN_OUTCLR   12'h018
`define GPSEN_OUTTGL   12'h01C
`define GPSEN_IN       12'h020
`define GPSEN_INTCTRL  12'h024
`define GPSEN_MASK0    12'h028
`define GPSEN_MASK1    12'h02C
`define GPSEN_FLAGS    12'h030
`define GPSEN_MULTI    12'h034
`define GPSEN_REMAP    12'h038
`define GPSEN_OUTSEL   12'h03C
`define GPSEN_PINCFG   12'h040
`define GPSEN_VECTOR   12'h060
`define GPSEN_CFG_RST  8'h00
`define GPSEN_VB_C     12'h004
`define GPSEN_VB_R     12'h008
`define GPSEN_VB_B     12'h04E
`define GPSEN_VB_D     12'h060
`define GPSEN_VB_G     12'h064
`define GPSEN_VB_M     12'h068
`define GPSEN_VSTEP    12'h002
`endif

// *** inc/gpsen_pkg.sv ***
package gpsen_pkg;
   typedef enum logic [2:0] {OC_TOTEM, OC_BUSKEEP, OC_PDOWN, OC_PUP,
                             OC_WOR, OC_WAND, OC_WORPD, OC_WANDPU} gpsen_opc_t;
   typedef enum logic [1:0] {SN_BOTH, SN_RISE, SN_FALL, SN_LOW} gpsen_sense_t;
   typedef enum logic [2:0] {BK_B, BK_C, BK_D, BK_G, BK_M, BK_R} gpsen_bank_t;
   typedef enum logic [1:0] {WR_IDLE, WR_RESP} gpsen_wst_t;
   typedef struct packed
   {
      gpsen_opc_t   opc;
      gpsen_sense_t sense;
      logic         inv;
      logic         slew;
      logic [1:0]   altsel;
   } gpsen_pcfg_t;
endpackage

// *** verilog/gpsen_port.sv ***
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "gpsen_map.svh"
module gpsen_port
#(
   parameter gpsen_pkg::gpsen_bank_t BANK = gpsen_pkg::BK_C
)
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        port_clk_en,
   input  wire logic        clk_per,
   input  wire logic        clk_rtc,
   input  wire logic [3:0]  evt_chan,
   input  wire logic [7:0]  alt_en,
   input  wire logic [7:0]  alt_out,
   input  wire logic [7:0]  alt_oe,
   input  wire logic [7:0]  pin_in,
   output logic [7:0]       pin_out,
   output logic [7:0]       pin_oe,
   output logic [7:0]       pin_pull_up,
   output logic [7:0]       pin_pull_dn,
   output logic [7:0]       pin_slew,
   output logic [7:0]       pin_value,
   output logic [7:0]       sense_evt,
   output logic [1:0]       port_irq,
   output logic [11:0]      irq_vec0,
   output logic [11:0]      irq_vec1,
   output logic             wake_req,
   output logic [7:0]       remap_sel
);
   import gpsen_pkg::*;

   typedef struct packed
   {
      gpsen_pcfg_t [7:0] pcfg;
      logic [7:0]  dir;
      logic [7:0]  outv;
      logic [7:0]  keep;
      logic [7:0]  in_ff;
      logic [7:0]  prev;
      logic [7:0]  flags;
      logic [7:0]  mask0;
      logic [7:0]  mask1;
      logic [7:0]  multi;
      logic [7:0]  remap;
      logic [7:0]  outsel;
      logic [1:0]  irqlvl;
      logic        aw_got;
      logic        w_got;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      gpsen_wst_t  wst;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [1:0]  bresp;
      logic        arready;
      logic [7:0]  pout;
      logic [7:0]  poe;
      logic [7:0]  pup;
      logic [7:0]  pdn;
      logic [7:0]  pslew;
      logic [7:0]  sevt;
      logic [1:0]  irq;
      logic        wake;
      logic        awrdy;
      logic        wrdy;
      logic        bvld;
      logic [11:0] vec0;
      logic [11:0] vec1;
   } gpsen_state_t;

   gpsen_state_t st_ff;
   gpsen_state_t nxt_st;

   // Register address decode, shared by read and write paths
   function automatic logic mapped(input logic [11:0] a);
      mapped = (a[1:0] == 2'h0) && ((a <= `GPSEN_OUTSEL) ||
               (a >= `GPSEN_PINCFG && a < `GPSEN_VECTOR) || a == `GPSEN_VECTOR);
   endfunction

   // Vector base per bank
   function automatic logic [11:0] vbase(input gpsen_bank_t b);
      case (b)
         BK_B:    vbase = `GPSEN_VB_B;
         BK_C:    vbase = `GPSEN_VB_C;
         BK_D:    vbase = `GPSEN_VB_D;
         BK_G:    vbase = `GPSEN_VB_G;
         BK_M:    vbase = `GPSEN_VB_M;
         BK_R:    vbase = `GPSEN_VB_R;
         default: vbase = `GPSEN_VB_C;
      endcase
   endfunction

   logic [7:0] sensed;
   logic [7:0] hit;
   logic [7:0] drv_val;
   logic [7:0] drv_oe;

   // R1: per-pin generate
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : g_pin
         always_comb
         begin
            // R9: invert before sense
            sensed[g] = pin_in[g] ^ st_ff.pcfg[g].inv;
            // R7: sense conditions
            case (st_ff.pcfg[g].sense)
               SN_BOTH: hit[g] = st_ff.in_ff[g] != st_ff.prev[g];
               SN_RISE: hit[g] = st_ff.in_ff[g] & ~st_ff.prev[g];
               SN_FALL: hit[g] = ~st_ff.in_ff[g] & st_ff.prev[g];
               SN_LOW:  hit[g] = ~st_ff.in_ff[g];
               default: hit[g] = 1'b0;
            endcase
            // R15: clock and event output select
            case (st_ff.pcfg[g].altsel)
               2'h1:    drv_val[g] = clk_per;
               2'h2:    drv_val[g] = clk_rtc;
               2'h3:    drv_val[g] = evt_chan[g % 4];
               default: drv_val[g] = st_ff.outv[g];
            endcase
            drv_val[g] = drv_val[g] ^ st_ff.pcfg[g].inv;
            drv_oe[g] = st_ff.dir[g];
            // R16: alternate function override
            if (alt_en[g])
            begin
               drv_val[g] = alt_out[g] ^ st_ff.pcfg[g].inv;
               drv_oe[g] = alt_oe[g];
            end
         end
      end
   endgenerate

   logic [31:0] wmask;
   logic [7:0]  wb;
   logic        wr_fire;
   logic        rd_fire;

   always_comb
   begin
      nxt_st = st_ff;
      wmask = {{8{st_ff.wstrb[3]}}, {8{st_ff.wstrb[2]}}, {8{st_ff.wstrb[1]}},
               {8{st_ff.wstrb[0]}}};
      wb = st_ff.wdata[7:0] & wmask[7:0];
      wr_fire = st_ff.aw_got && st_ff.w_got && st_ff.wst == WR_IDLE;
      rd_fire = s_axi_arvalid && st_ff.arready;

      // R8: sample input synchronously every clock, whether or not port_clk_en is set
      nxt_st.in_ff = sensed;
      nxt_st.prev = st_ff.in_ff;
      // R10: wake from raw asynchronous compare in unclocked mode
      nxt_st.wake = !port_clk_en && |((sensed ^ st_ff.in_ff) & (st_ff.mask0 | st_ff.mask1));

      if (s_axi_awvalid && !st_ff.aw_got)
      begin
         nxt_st.aw_got = 1'b1;
         nxt_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_ff.w_got)
      begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = s_axi_wdata;
         nxt_st.wstrb = s_axi_wstrb;
      end

      if (wr_fire)
      begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.wst = WR_RESP;
         nxt_st.bresp = mapped(st_ff.awaddr) ? 2'h0 : 2'h2;
         case (st_ff.awaddr)
            `GPSEN_DIR:     nxt_st.dir = wb | (st_ff.dir & ~wmask[7:0]);
            // R12: set, clear, toggle; R13: untouched direction bits kept
            `GPSEN_DIRSET:  nxt_st.dir = st_ff.dir | wb;
            `GPSEN_DIRCLR:  nxt_st.dir = st_ff.dir & ~wb;
            `GPSEN_DIRTGL:  nxt_st.dir = st_ff.dir ^ wb;
            `GPSEN_OUT:     nxt_st.outv = wb | (st_ff.outv & ~wmask[7:0]);
            `GPSEN_OUTSET:  nxt_st.outv = st_ff.outv | wb;
            `GPSEN_OUTCLR:  nxt_st.outv = st_ff.outv & ~wb;
            `GPSEN_OUTTGL:  nxt_st.outv = st_ff.outv ^ wb;
            `GPSEN_INTCTRL: nxt_st.irqlvl = st_ff.wdata[1:0];
            // R11: two masks
            `GPSEN_MASK0:   nxt_st.mask0 = wb;
            `GPSEN_MASK1:   nxt_st.mask1 = wb;
            `GPSEN_FLAGS:   nxt_st.flags = st_ff.flags & ~wb;
            `GPSEN_MULTI:   nxt_st.multi = wb;
            // R17: remap selection
            `GPSEN_REMAP:   nxt_st.remap = wb;
            `GPSEN_OUTSEL:  nxt_st.outsel = wb;
            default:
            begin
               // R14: multi-pin configuration write
               if (st_ff.awaddr >= `GPSEN_PINCFG && st_ff.awaddr < `GPSEN_VECTOR)
               begin
                  for (int i = 0; i < 8; i++)
                  begin
                     if (st_ff.multi[i] || st_ff.awaddr[4:2] == i[2:0])
                     begin
                        // R2: driver and pull; R3, R4, R6 fields
                        nxt_st.pcfg[i] = gpsen_pcfg_t'(st_ff.wdata[8:0]);
                     end
                  end
               end
            end
         endcase
      end
      if (st_ff.wst == WR_RESP && s_axi_bready)
      begin
         nxt_st.wst = WR_IDLE;
      end
      // Handshake outputs registered from the next state
      nxt_st.awrdy = !nxt_st.aw_got;
      nxt_st.wrdy = !nxt_st.w_got;
      nxt_st.bvld = nxt_st.wst == WR_RESP;
      // R19: R20: R21: R22: bank vector base
      nxt_st.vec0 = vbase(BANK);
      // R23: base plus step
      nxt_st.vec1 = vbase(BANK) + `GPSEN_VSTEP;

      // Sticky flags, set wins over clear
      nxt_st.flags = nxt_st.flags | hit;
      nxt_st.sevt = hit;
      // R11: masked interrupt outputs
      nxt_st.irq[0] = |(st_ff.flags & st_ff.mask0) && st_ff.irqlvl[0];
      nxt_st.irq[1] = |(st_ff.flags & st_ff.mask1) && st_ff.irqlvl[1];

      nxt_st.arready = !st_ff.rvalid && !rd_fire;
      if (rd_fire)
      begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
         nxt_st.rdata = 32'h0;
         case (s_axi_araddr)
            `GPSEN_DIR, `GPSEN_DIRSET, `GPSEN_DIRCLR, `GPSEN_DIRTGL:
               nxt_st.rdata[7:0] = st_ff.dir;
            `GPSEN_OUT, `GPSEN_OUTSET, `GPSEN_OUTCLR, `GPSEN_OUTTGL:
               nxt_st.rdata[7:0] = st_ff.outv;
            `GPSEN_IN:      nxt_st.rdata[7:0] = st_ff.in_ff;
            `GPSEN_INTCTRL: nxt_st.rdata[1:0] = st_ff.irqlvl;
            `GPSEN_MASK0:   nxt_st.rdata[7:0] = st_ff.mask0;
            `GPSEN_MASK1:   nxt_st.rdata[7:0] = st_ff.mask1;
            `GPSEN_FLAGS:   nxt_st.rdata[7:0] = st_ff.flags;
            `GPSEN_MULTI:   nxt_st.rdata[7:0] = st_ff.multi;
            `GPSEN_REMAP:   nxt_st.rdata[7:0] = st_ff.remap;
            `GPSEN_OUTSEL:  nxt_st.rdata[7:0] = st_ff.outsel;
            // R18: vector read-back
            `GPSEN_VECTOR:  nxt_st.rdata[11:0] = vbase(BANK);
            default:
            begin
               if (mapped(s_axi_araddr))
               begin
                  nxt_st.rdata[8:0] = st_ff.pcfg[s_axi_araddr[4:2]];
               end
            end
         endcase
      end
      else if (st_ff.rvalid && s_axi_rready)
      begin
         nxt_st.rvalid = 1'b0;
      end

      // Pin drive per output configuration
      for (int i = 0; i < 8; i++)
      begin
         nxt_st.pout[i] = drv_val[i];
         nxt_st.poe[i] = drv_oe[i];
         nxt_st.pup[i] = 1'b0;
         nxt_st.pdn[i] = 1'b0;
         nxt_st.pslew[i] = st_ff.pcfg[i].slew;
         if (drv_oe[i])
         begin
            nxt_st.keep[i] = drv_val[i];
         end
         case (st_ff.pcfg[i].opc)
            OC_PUP:    nxt_st.pup[i] = !drv_oe[i];
            OC_PDOWN:  nxt_st.pdn[i] = !drv_oe[i];
            // R5: bus-keeper follows last level
            OC_BUSKEEP:
            begin
               nxt_st.pup[i] = !drv_oe[i] && st_ff.keep[i];
               nxt_st.pdn[i] = !drv_oe[i] && !st_ff.keep[i];
            end
            // R3: wired modes drive one level only
            OC_WOR, OC_WORPD:
            begin
               nxt_st.poe[i] = drv_oe[i] && drv_val[i];
               nxt_st.pdn[i] = st_ff.pcfg[i].opc == OC_WORPD;
            end
            OC_WAND, OC_WANDPU:
            begin
               nxt_st.poe[i] = drv_oe[i] && !drv_val[i];
               nxt_st.pup[i] = st_ff.pcfg[i].opc == OC_WANDPU;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_ff <= '0;
         st_ff.arready <= 1'b1;
         st_ff.awrdy <= 1'h1;
         st_ff.wrdy <= 1'h1;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign s_axi_awready = st_ff.awrdy;
   assign s_axi_wready  = st_ff.wrdy;
   assign s_axi_bvalid  = st_ff.bvld;
   assign s_axi_bresp   = st_ff.bresp;
   assign s_axi_arready = st_ff.arready;
   assign s_axi_rvalid  = st_ff.rvalid;
   assign s_axi_rdata   = st_ff.rdata;
   assign s_axi_rresp   = st_ff.rresp;
   assign pin_out       = st_ff.pout;
   assign pin_oe        = st_ff.poe;
   assign pin_pull_up   = st_ff.pup;
   assign pin_pull_dn   = st_ff.pdn;
   assign pin_slew      = st_ff.pslew;
   assign pin_value     = st_ff.in_ff;
   assign sense_evt     = st_ff.sevt;
   assign port_irq      = st_ff.irq;
   assign irq_vec0      = st_ff.vec0;
   assign irq_vec1      = st_ff.vec1;
   assign wake_req      = st_ff.wake;
   assign remap_sel     = st_ff.remap;
endmodule

// *** verif/gpsen_port_assertions.sv ***
`timescale 1ns/1ps
`include "gpsen_map.svh"
module gpsen_chk
#(
   parameter gpsen_pkg::gpsen_bank_t BANK = gpsen_pkg::BK_C
)
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        port_clk_en,
   input wire logic        wake_req,
   input wire logic [7:0]  pin_pull_up,
   input wire logic [7:0]  pin_pull_dn,
   input wire logic [11:0] irq_vec0,
   input wire logic [11:0] irq_vec1
);
   import gpsen_pkg::*;
   logic [11:0] vb;
   always_comb
   begin
      case (BANK)
         BK_B:    vb = `GPSEN_VB_B;
         BK_D:    vb = `GPSEN_VB_D;
         BK_G:    vb = `GPSEN_VB_G;
         BK_M:    vb = `GPSEN_VB_M;
         BK_R:    vb = `GPSEN_VB_R;
         default: vb = `GPSEN_VB_C;
      endcase
   end
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("Write response dropped early");
   chk_rresp_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("Read response dropped early");
   chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read answer late");
   chk_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("Write answer late");
   chk_vec_base: assert property ($past(aresetn) |-> irq_vec0 == vb)
      else $error("Vector base wrong");
   chk_vec_step: assert property ($past(aresetn) |-> irq_vec1 == irq_vec0 + `GPSEN_VSTEP)
      else $error("Second vector wrong");
   chk_wake_sync: assert property (port_clk_en [*3] |-> !wake_req)
      else $error("Wake raised while clocked");
   chk_pull_excl: assert property ((pin_pull_up & pin_pull_dn) == 8'h00)
      else $error("Pull up and down together");
endmodule
bind gpsen_port gpsen_chk #(.BANK(BANK)) u_chk
(
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .port_clk_en, .wake_req, .pin_pull_up, .pin_pull_dn, .irq_vec0, .irq_vec1
);

// *** verif/gpsen_board.sv ***
`timescale 1ns/1ps
module gpsen_board
(
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pin_pull_up,
   input  wire logic [7:0] pin_pull_dn,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   input  wire logic       aclk,
   output logic [7:0]      pin_in
);
   logic [7:0] lvl;
   logic [7:0] q = 8'h00;
   assign pin_in = q;
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (pin_oe[i])
            lvl[i] = pin_out[i];
         else if (ext_en[i])
            lvl[i] = ext_val[i];
         else if (pin_pull_up[i] | pin_pull_dn[i])
            lvl[i] = pin_pull_up[i];
         else
            lvl[i] = ~q[i];
      end
   end
   always @(posedge aclk)
      q <= lvl;
endmodule

// *** verif/test_gpio_port_with_pin_sensing.sv ***
`timescale 1ns/1ps
`include "gpsen_map.svh"
module test_gpio_port_with_pin_sensing;
   import gpsen_pkg::*;
   logic         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic         s_axi_rready, port_clk_en, clk_per, clk_rtc, s_axi_awready, s_axi_wready;
   logic         s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake_req;
   logic [11:0]  s_axi_awaddr, s_axi_araddr, irq_vec0, irq_vec1;
   logic [31:0]  s_axi_wdata, s_axi_rdata;
   logic [3:0]   s_axi_wstrb, evt_chan;
   logic [1:0]   s_axi_bresp, s_axi_rresp, port_irq;
   logic [7:0]   alt_en, alt_out, alt_oe, pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_dn;
   logic [7:0]   pin_slew, pin_value, sense_evt, remap_sel, ext_val;
   int           error_cnt, num_checks, k;
   logic [7:0]   dat [4] = '{8'hA5, 8'h0A, 8'h21, 8'hFF};
   logic [7:0]   rmw [4] = '{8'hA5, 8'hAF, 8'h8E, 8'h71};
   gpsen_sense_t sn [5] = '{SN_BOTH, SN_RISE, SN_FALL, SN_LOW, SN_RISE};
   localparam logic [4:0] ex_r = 5'h0B;
   localparam logic [4:0] ex_f = 5'h1D;
   gpsen_port #(.BANK(BK_C)) u_dut
   (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_clk_en, .clk_per, .clk_rtc,
      .evt_chan, .alt_en, .alt_out, .alt_oe, .pin_in, .pin_out, .pin_oe, .pin_pull_up,
      .pin_pull_dn, .pin_slew, .pin_value, .sense_evt, .port_irq, .irq_vec0, .irq_vec1,
      .wake_req, .remap_sel
   );
   gpsen_board u_board
   (
      .pin_out, .pin_oe, .pin_pull_up, .pin_pull_dn, .ext_en(8'hFF), .ext_val, .aclk, .pin_in
   );
   int           evt_cnt = 0;
   always @(posedge aclk)
      evt_cnt <= evt_cnt + int'(sense_evt[3] === 1'h1);
   initial
   begin
      aclk = 1'h0;
      forever
         #25 aclk = ~aclk;
   end
   task automatic give_verdict();
      $display("Checks %0d, errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         error_cnt++;
         $display("Error at %0t: seen %0h expected %0h", $time, s, e);
      end
   endtask
   task automatic limit(input int n);
      if (n >= 50)
      begin
         error_cnt++;
         give_verdict();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      int n;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'h0;
      end
      while (!s_axi_bvalid && n < 50);
      s_axi_bready <= 1'h0;
      limit(n);
      chk(s_axi_bresp, r);
      repeat (3) @(posedge aclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arready)
            s_axi_arvalid <= 1'h0;
      end
      while (!s_axi_rvalid && n < 50);
      s_axi_rready <= 1'h0;
      limit(n);
      chk(s_axi_rresp, r);
      if (r == 2'h0)
         chk(s_axi_rdata, e);
   endtask
   task automatic pin(input logic [7:0] v);
      ext_val <= v;
      repeat (6) @(posedge aclk);
   endtask
   function automatic logic [31:0] cfg(gpsen_opc_t o, gpsen_sense_t s, logic i, logic [1:0] a);
      gpsen_pcfg_t c;
      c = '{o, s, i, (o == OC_PUP), a};
      return {23'h0, c};
   endfunction
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, alt_en, alt_out, alt_oe, ext_val} = '0;
      {clk_per, clk_rtc, evt_chan, error_cnt, num_checks} = '0;
      s_axi_wstrb = 4'hF;
      port_clk_en = 1'h1;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      rd(`GPSEN_DIR, 32'h0);
      rd(`GPSEN_VECTOR, `GPSEN_VB_C);
      chk(irq_vec1, `GPSEN_VB_C + `GPSEN_VSTEP);
      for (k = 0; k < 8; k++)
      begin
         wr(12'(k / 4 * 16 + k % 4 * 4), {24'h0, dat[k % 4]});
         rd(12'(k / 4 * 16), {24'h0, rmw[k % 4]});
      end
      chk(pin_oe, 8'h71);
      chk(pin_out & pin_oe, 8'h71);
      wr(12'h100, 32'hFF, 2'h2);
      rd(12'h100, 32'h0, 2'h2);
      rd(`GPSEN_DIR, 32'h71);
      wr(`GPSEN_MULTI, 32'h0C);
      wr(`GPSEN_PINCFG, cfg(OC_PUP, SN_BOTH, 1'h0, 2'h0));
      chk(pin_pull_up, 8'h0C);
      chk(pin_slew, 8'h0D);
      wr(`GPSEN_MULTI, 32'h00);
      for (k = 7; k >= 0; k--)
      begin
         wr(12'h05C, cfg(gpsen_opc_t'(k), SN_BOTH, 1'h0, 2'h0));
         chk(pin_pull_up[7], k == 3 || k == 7);
         chk(pin_pull_dn[7], k == 1 || k == 2 || k == 6);
      end
      wr(`GPSEN_PINCFG, cfg(OC_BUSKEEP, SN_BOTH, 1'h0, 2'h0));
      wr(`GPSEN_DIRCLR, 32'h01);
      chk(pin_pull_up[0], 1'h1);
      wr(`GPSEN_OUTCLR, 32'h01);
      wr(`GPSEN_DIRSET, 32'h01);
      wr(`GPSEN_DIRCLR, 32'h01);
      chk(pin_pull_dn[0], 1'h1);
      for (k = 0; k < 5; k++)
      begin
         pin(8'h00);
         wr(12'h04C, cfg(OC_TOTEM, sn[k], k == 4, 2'h0));
         wr(`GPSEN_FLAGS, 32'hFF);
         pin(8'h08);
         rd(`GPSEN_FLAGS, {28'h0, ex_r[k], 3'h0});
         chk(pin_value[3], k != 4);
         wr(`GPSEN_FLAGS, 32'hFF);
         pin(8'h00);
         rd(`GPSEN_FLAGS, {28'h0, ex_f[k], 3'h0});
      end
      wr(12'h04C, cfg(OC_TOTEM, SN_BOTH, 1'h0, 2'h0));
      wr(`GPSEN_MASK0, 32'h08);
      wr(`GPSEN_INTCTRL, 32'h3);
      wr(`GPSEN_FLAGS, 32'hFF);
      chk(port_irq, 2'h0);
      k = evt_cnt;
      pin(8'h08);
      chk(evt_cnt - k, 1);
      chk(port_irq, 2'h1);
      wr(`GPSEN_MASK1, 32'h08);
      chk(port_irq, 2'h3);
      wr(`GPSEN_INTCTRL, 32'h2);
      chk(port_irq, 2'h2);
      wr(`GPSEN_FLAGS, 32'hFF);
      chk(port_irq, 2'h0);
      port_clk_en <= 1'h0;
      ext_val <= 8'h00;
      for (k = 0; k < 20 && wake_req !== 1'h1; k++)
         @(posedge aclk);
      chk(wake_req, 1'h1);
      port_clk_en <= 1'h1;
      pin(8'h00);
      chk(wake_req, 1'h0);
      clk_rtc <= 1'h1;
      for (k = 0; k < 4; k++)
      begin
         wr(12'h058, cfg(OC_TOTEM, SN_BOTH, 1'h0, 2'(k)));
         chk(pin_out[6], k == 0 || k == 2);
      end
      evt_chan <= 4'h4;
      pin(8'h00);
      chk(pin_out[6], 1'h1);
      {alt_en, alt_oe} <= 16'h4040;
      pin(8'h00);
      chk(pin_out[6], 1'h0);
      alt_oe <= 8'h00;
      pin(8'h00);
      chk(pin_oe[6], 1'h0);
      wr(`GPSEN_REMAP, 32'h5A);
      chk(remap_sel, 8'h5A);
      give_verdict();
   end
endmodule
